/* src/counter_timer_unit_pkg.sv */
package counter_timer_unit_pkg;

  // Unit geometry
  localparam int N_CHANNELS = 4;
  localparam int N_ZC_OUTPUTS = 3;
  localparam int CHANNEL_SEL_W = 2;
  localparam int DATA_W = 8;
  localparam int VECTOR_W = 5;

  // Channel mode word field positions
  localparam int CTRL_INT_EN_BIT = 7;
  localparam int CTRL_COUNTER_MODE_BIT = 6;
  localparam int CTRL_PRESC256_BIT = 5;
  localparam int CTRL_RISING_EDGE_BIT = 4;
  localparam int CTRL_TRIG_START_BIT = 3;
  localparam int CTRL_TC_FOLLOWS_BIT = 2;
  localparam int CTRL_SOFT_RESET_BIT = 1;
  localparam int CTRL_IS_CONTROL_BIT = 0;

  // Only bits 7..3 are stored; 2..0 act on the write itself
  localparam logic [7:0] CTRL_STORED_MASK = 8'hF8;
  localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;

  // Interrupt vector layout
  localparam int VECTOR_HIGH_LSB = 3;
  localparam logic VECTOR_LOW_BIT = 1'b0;
  localparam logic [VECTOR_W-1:0] VECTOR_RESET_VALUE = 5'h00;

  // Prescaler factors and reload values
  localparam int PRESC_SMALL = 16;
  localparam int PRESC_LARGE = 256;
  localparam logic [7:0] PRESC_SMALL_LOAD = 8'(PRESC_SMALL - 1);
  localparam logic [7:0] PRESC_LARGE_LOAD = 8'(PRESC_LARGE - 1);

  // Down counter constants; all zeros means 256
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_RESET_VALUE = 8'h00;
  localparam logic [7:0] DATA_RESET_VALUE = 8'h00;

  // Return-from-interrupt opcode pair seen on instruction fetches
  localparam logic [7:0] OPCODE_PREFIX = 8'hED;
  localparam logic [7:0] OPCODE_RETI = 8'h4D;

  // Channel sequencer states, Gray along idle -> armed -> run
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_ARMED = 2'b01,
    CH_RUN = 2'b11
  } chan_state_t;

endpackage

/* src/trigger_edge_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface trigger_edge_if;
  logic rise;
  logic fall;

  modport src (
    output rise,
    output fall
  );

  modport dst (
    input rise,
    input fall
  );
endinterface

`default_nettype wire

/* src/trigger_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module trigger_edge_detect (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Raw trigger pin
  input wire logic i_pin,
  // Detected edges
  trigger_edge_if.src edges
);

  logic sync_first;
  logic sync_second;
  logic prev;
  logic [1:0] warm;
  logic primed;

  // Two-stage synchroniser, then one stage of history
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_first <= i_pin;
      sync_second <= sync_first;
      prev <= sync_second;
    end
  end

  // Edges masked until history holds a real pin sample, so no false edge after reset
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      warm <= 2'h0;
    end else if (!primed) begin
      warm <= warm + 2'h1;
    end
  end

  assign primed = &warm;
  assign edges.rise = primed & sync_second & ~prev;
  assign edges.fall = primed & ~sync_second & prev;

endmodule // trigger_edge_detect

`default_nettype wire

/* src/counter_timer_unit.sv */
// Behaviour
// - Every channel has its own trigger pin; counter mode counts its active edges.
// - Timer mode with triggered start begins timing on an active trigger edge.
// - Channels 0..2 pulse a zero-count output high; channel 3 has none.
// - Mode bit 6 set selects counter mode; prescaler bypassed, edges decrement.
// - Each trigger edge decrements on a later clock edge; late edges one more.
// - Mode bit 4 picks rising or falling trigger edge for counting and starting.
// - Mode bit 7 set makes every zero count request an interrupt.
// - At zero count the counter reloads from the time constant without a gap.
// - A new time constant on a running channel waits until the count hits zero.
// - Bit 6 clear selects timer mode; prescaler output decrements the counter.
// - In timer mode bit 5 set divides the clock by 256.
// - Time constants from 1 to 256 are accepted.
// - Auto-start timer runs from the cycle after the time constant write.
// - Triggered timer starts after the first trigger edge following the load.
// - A trigger edge too close to the clock starts counting one clock later.
// - A word with bit 0 set is the selected channel's mode word unless a time constant is due.
// - A mode word with bit 7 clear drops that channel's pending request, unless a zero count lands in that cycle.
// - One stored vector serves all channels; channel code is inserted.
// - In timer mode bit 5 clear divides the clock by 16.
// - A time constant of zero means 256.
// - Bit 2 set makes the next word to that channel the time constant.
// - Bit 1 set stops the channel; bits 7..3 of that same word are still stored as the mode.
`timescale 1ns/1ps
`default_nettype none

module counter_timer_unit
  import counter_timer_unit_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  // Host bus
  input wire logic [DATA_W-1:0] I_DATA,
  output logic [DATA_W-1:0] O_DATA,
  output logic O_DATA_OE,
  input wire logic I_CHANNEL_SELECT_LOW,
  input wire logic I_CHANNEL_SELECT_HIGH,
  input wire logic I_CHIP_ENABLE_N,
  input wire logic I_M1_N,
  input wire logic I_IORQ_N,
  input wire logic I_RD_N,
  // Interrupt request and priority chain
  output logic O_INT_N,
  output logic O_INT_N_OE,
  input wire logic I_IEI,
  output logic O_IEO,
  // Channel pins
  input wire logic [N_CHANNELS-1:0] I_EXT_COUNT_TRIGGER,
  output logic [N_ZC_OUTPUTS-1:0] O_ZERO_COUNT_PULSE_OUT
);

  logic [CHANNEL_SEL_W-1:0] sel;
  logic wr_cond;
  logic rd_cond;
  logic ack_cond;
  logic fetch_cond;
  logic wr_cond_d;
  logic rd_cond_d;
  logic ack_cond_d;
  logic fetch_cond_d;
  logic wr_take;
  logic rd_take;
  logic ack_take;
  logic fetch_take;
  logic ack_owner;
  logic saw_prefix;
  logic reti_seen;
  logic [VECTOR_W-1:0] vector;
  logic [DATA_W-1:0] data_out;
  logic [N_CHANNELS-1:0] pending;
  logic [N_CHANNELS-1:0] zero_pulse;
  logic [N_CHANNELS-1:0] ack_clear;
  logic [N_CHANNELS-1:0] under_service;
  logic [N_CHANNELS-1:0] next_under_service;
  logic [CHANNEL_SEL_W-1:0] next_ack_ch;
  logic [DATA_W-1:0] down_count [N_CHANNELS];

  // Bus cycle decode
  assign sel = {I_CHANNEL_SELECT_HIGH, I_CHANNEL_SELECT_LOW};
  assign wr_cond = ~I_CHIP_ENABLE_N & ~I_IORQ_N & I_RD_N & I_M1_N;
  assign rd_cond = ~I_CHIP_ENABLE_N & ~I_IORQ_N & ~I_RD_N & I_M1_N;
  assign ack_cond = ~I_IORQ_N & ~I_M1_N;
  assign fetch_cond = ~I_M1_N & ~I_RD_N & I_IORQ_N;

  // One action per bus cycle, on its first sampled edge
  assign wr_take = wr_cond & ~wr_cond_d;
  assign rd_take = rd_cond & ~rd_cond_d;
  assign ack_take = ack_cond & ~ack_cond_d & I_IEI & (|pending);
  assign fetch_take = fetch_cond & ~fetch_cond_d;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      wr_cond_d <= 1'b0;
      rd_cond_d <= 1'b0;
      ack_cond_d <= 1'b0;
      fetch_cond_d <= 1'b0;
    end else begin
      wr_cond_d <= wr_cond;
      rd_cond_d <= rd_cond;
      ack_cond_d <= ack_cond;
      fetch_cond_d <= fetch_cond;
    end
  end

  // Shared vector register, written through channel 0 with bit 0 clear
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      vector <= VECTOR_RESET_VALUE;
    end else if (wr_take && sel == '0 && !I_DATA[CTRL_IS_CONTROL_BIT]
                 && !channel[0].expect_tc) begin
      vector <= I_DATA[DATA_W-1:VECTOR_HIGH_LSB];
    end
  end

  // Highest priority pending channel; channel 0 wins
  always_comb begin
    next_ack_ch = '0;
    for (int k = N_CHANNELS - 1; k >= 0; k--) begin
      if (pending[k]) begin
        next_ack_ch = CHANNEL_SEL_W'(k);
      end
    end
  end

  always_comb begin
    ack_clear = '0;
    if (ack_take) begin
      ack_clear[next_ack_ch] = 1'b1;
    end
  end

  // Read data and vector word
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      data_out <= DATA_RESET_VALUE;
    end else if (ack_take) begin
      data_out <= {vector, next_ack_ch, VECTOR_LOW_BIT};
    end else if (rd_take) begin
      data_out <= down_count[sel];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      ack_owner <= 1'b0;
    end else if (!ack_cond) begin
      ack_owner <= 1'b0;
    end else if (ack_take) begin
      ack_owner <= 1'b1;
    end
  end

  // Return-from-interrupt detection on opcode fetches
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      saw_prefix <= 1'b0;
    end else if (fetch_take) begin
      saw_prefix <= (I_DATA == OPCODE_PREFIX);
    end
  end

  assign reti_seen = fetch_take & saw_prefix & (I_DATA == OPCODE_RETI);

  // Service tracking: ack marks, return clears lowest-numbered marked channel
  always_comb begin
    next_under_service = under_service;
    if (reti_seen) begin
      for (int k = N_CHANNELS - 1; k >= 0; k--) begin
        if (under_service[k]) begin
          next_under_service = under_service & ~(N_CHANNELS'(1) << k);
        end
      end
    end
    next_under_service = next_under_service | ack_clear;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      under_service <= '0;
    end else begin
      under_service <= next_under_service;
    end
  end

  // Channels
  for (genvar i = 0; i < N_CHANNELS; i++) begin : channel
    trigger_edge_if tif ();
    chan_state_t state;
    logic [7:0] ctrl;
    logic [7:0] tc;
    logic [7:0] cnt;
    logic [7:0] presc;
    logic [7:0] presc_load;
    logic tc_valid;
    logic expect_tc;
    logic pend;
    logic zc;
    logic wr_here;
    logic is_tc_write;
    logic is_ctrl_write;
    logic counter_mode;
    logic trig_edge;
    logic tick;
    logic zero_hit;

    trigger_edge_detect sync (
      .i_clock(I_CLOCK),
      .i_srst(I_SRST),
      .i_pin(I_EXT_COUNT_TRIGGER[i]),
      .edges(tif)
    );

    assign wr_here = wr_take & (sel == CHANNEL_SEL_W'(i));
    assign is_tc_write = wr_here & expect_tc;
    assign is_ctrl_write = wr_here & ~expect_tc & I_DATA[CTRL_IS_CONTROL_BIT];
    assign counter_mode = ctrl[CTRL_COUNTER_MODE_BIT];
    assign trig_edge = ctrl[CTRL_RISING_EDGE_BIT] ? tif.rise : tif.fall;
    assign presc_load = ctrl[CTRL_PRESC256_BIT] ? PRESC_LARGE_LOAD : PRESC_SMALL_LOAD;

    // Decrement source: trigger edges or prescaler output
    assign tick = (state == CH_RUN) & (counter_mode ? trig_edge : (presc == '0));
    assign zero_hit = tick & (cnt == COUNT_ONE);

    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        ctrl <= CTRL_RESET_VALUE;
      end else if (is_ctrl_write) begin
        ctrl <= I_DATA & CTRL_STORED_MASK;
      end
    end

    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        expect_tc <= 1'b0;
      end else if (is_tc_write) begin
        expect_tc <= 1'b0;
      end else if (is_ctrl_write) begin
        expect_tc <= I_DATA[CTRL_TC_FOLLOWS_BIT];
      end
    end

    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        tc <= COUNT_RESET_VALUE;
        tc_valid <= 1'b0;
      end else if (is_tc_write) begin
        tc <= I_DATA;
        tc_valid <= 1'b1;
      end
    end

    // Sequencer: idle until a time constant exists
    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        state <= CH_IDLE;
      end else if (is_ctrl_write && I_DATA[CTRL_SOFT_RESET_BIT]) begin
        state <= CH_IDLE;
      end else if (is_ctrl_write && !I_DATA[CTRL_TC_FOLLOWS_BIT] && tc_valid
                   && state == CH_IDLE && !I_DATA[CTRL_COUNTER_MODE_BIT]
                   && I_DATA[CTRL_TRIG_START_BIT]) begin
        state <= CH_ARMED;
      end else if (is_tc_write && state == CH_IDLE) begin
        if (!counter_mode && ctrl[CTRL_TRIG_START_BIT]) begin
          state <= CH_ARMED;
        end else begin
          state <= CH_RUN;
        end
      end else begin
        case (state)
          CH_ARMED: begin
            if (trig_edge) begin
              state <= CH_RUN;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Prescaler restarts whenever the channel is not running
    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        presc <= PRESC_SMALL_LOAD;
      end else if (state != CH_RUN) begin
        presc <= presc_load;
      end else if (presc == '0) begin
        presc <= presc_load;
      end else begin
        presc <= presc - 8'h01;
      end
    end

    // Down counter; zero byte wraps through 8'hFF, i.e. 256 steps
    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        cnt <= COUNT_RESET_VALUE;
      end else if (is_tc_write && state == CH_IDLE) begin
        cnt <= I_DATA;
      end else if (tick) begin
        if (cnt == COUNT_ONE) begin
          cnt <= tc;
        end else begin
          cnt <= cnt - COUNT_ONE;
        end
      end
    end

    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        zc <= 1'b0;
      end else begin
        zc <= zero_hit;
      end
    end

    // Pending request; a new zero count beats an acknowledge
    always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
        pend <= 1'b0;
      end else if (zero_hit && ctrl[CTRL_INT_EN_BIT]) begin
        pend <= 1'b1;
      end else if (ack_clear[i]) begin
        pend <= 1'b0;
      end else if (is_ctrl_write && !I_DATA[CTRL_INT_EN_BIT]) begin
        pend <= 1'b0;
      end
    end

    assign down_count[i] = cnt;
    assign pending[i] = pend;
    assign zero_pulse[i] = zc;
  end

  // Outputs
  assign O_ZERO_COUNT_PULSE_OUT = zero_pulse[N_ZC_OUTPUTS-1:0];
  assign O_DATA = data_out;
  assign O_DATA_OE = (rd_cond & rd_cond_d) | (ack_cond & ack_owner);
  assign O_INT_N = 1'b0;
  assign O_INT_N_OE = |pending;
  assign O_IEO = I_IEI & ~(|under_service);

endmodule // counter_timer_unit

`default_nettype wire

/* testbench/counter_timer_unit_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module counter_timer_unit_assertions
  import counter_timer_unit_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  // Host bus
  input wire logic [DATA_W-1:0] O_DATA,
  input wire logic O_DATA_OE,
  input wire logic I_CHIP_ENABLE_N,
  input wire logic I_M1_N,
  input wire logic I_IORQ_N,
  input wire logic I_RD_N,
  // Interrupt
  input wire logic O_INT_N,
  input wire logic O_INT_N_OE,
  input wire logic I_IEI,
  input wire logic O_IEO,
  // Channel pins
  input wire logic [N_ZC_OUTPUTS-1:0] O_ZERO_COUNT_PULSE_OUT
);
  logic wr_cond;
  logic rd_cond;
  logic ack_cond;
  logic rd_prev;
  logic ack_prev;
  logic seen_wr;

  assign wr_cond = !I_CHIP_ENABLE_N && !I_IORQ_N && I_RD_N && I_M1_N;
  assign rd_cond = !I_CHIP_ENABLE_N && !I_IORQ_N && !I_RD_N && I_M1_N;
  assign ack_cond = !I_IORQ_N && !I_M1_N;

  always_ff @(posedge I_CLOCK) begin
    rd_prev <= rd_cond;
  end

  always_ff @(posedge I_CLOCK) begin
    ack_prev <= ack_cond;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      seen_wr <= 1'b0;
    end else if (wr_cond) begin
      seen_wr <= 1'b1;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  AST_ZC_ONE_CYCLE: assert property (
    (O_ZERO_COUNT_PULSE_OUT & $past(O_ZERO_COUNT_PULSE_OUT)) == 3'h0) else $error("zc wide");
  AST_IDLE_UNTIL_WRITE: assert property (
    !seen_wr |-> O_ZERO_COUNT_PULSE_OUT == 3'h0 && !O_INT_N_OE) else $error("not idle");
  AST_INT_LOW: assert property (O_INT_N_OE |-> !O_INT_N) else $error("int level");
  AST_ACK_VECTOR: assert property (
    ack_cond && !ack_prev && I_IEI && O_INT_N_OE |=> O_DATA_OE && !O_DATA[0])
    else $error("no vector");
  AST_IEO_BLOCK: assert property (!I_IEI |-> !O_IEO) else $error("ieo high");
  AST_READ_ANSWER: assert property (
    rd_cond && !rd_prev |=> O_DATA_OE) else $error("no read data");
  AST_WRITE_QUIET: assert property (wr_cond |-> !O_DATA_OE) else $error("drive on write");
  AST_OE_RELEASE: assert property (I_IORQ_N |-> !O_DATA_OE) else $error("bus held");

  cover property (rd_cond && !rd_prev);
  cover property (ack_cond && !ack_prev && O_INT_N_OE);
  cover property (O_ZERO_COUNT_PULSE_OUT != 3'h0);
endmodule // counter_timer_unit_assertions

bind counter_timer_unit counter_timer_unit_assertions u_chk (
  .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE),
  .I_CHIP_ENABLE_N(I_CHIP_ENABLE_N), .I_M1_N(I_M1_N), .I_IORQ_N(I_IORQ_N), .I_RD_N(I_RD_N),
  .O_INT_N(O_INT_N), .O_INT_N_OE(O_INT_N_OE), .I_IEI(I_IEI), .O_IEO(O_IEO),
  .O_ZERO_COUNT_PULSE_OUT(O_ZERO_COUNT_PULSE_OUT));

`default_nettype wire

/* testbench/host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  // Clock
  input wire logic i_clock,
  // Bus as seen on the wire
  input wire logic [7:0] i_data,
  // Bus drive
  output logic [7:0] o_data,
  output logic o_cs_low,
  output logic o_cs_high,
  output logic o_ce_n,
  output logic o_m1_n,
  output logic o_iorq_n,
  output logic o_rd_n
);
  initial begin
    o_data = 8'h00;
    {o_ce_n, o_m1_n, o_iorq_n, o_rd_n} = 4'hF;
    {o_cs_high, o_cs_low} = 2'b00;
  end

  // Pins are {ce_n, m1_n, iorq_n, rd_n}
  task automatic cycle(input logic [3:0] pins, input logic [1:0] ch,
                       input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clock);
    {o_ce_n, o_m1_n, o_iorq_n, o_rd_n} <= pins;
    {o_cs_high, o_cs_low} <= ch;
    o_data <= d;
    repeat (2) @(posedge i_clock);
    q = i_data;
    {o_ce_n, o_m1_n, o_iorq_n, o_rd_n} <= 4'hF;
    // Released lines show the inverse, not a stale copy
    o_data <= ~d;
  endtask

  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    logic [7:0] q;
    cycle(4'h5, ch, d, q);
  endtask

  task automatic rd(input logic [1:0] ch, output logic [7:0] q);
    cycle(4'h4, ch, 8'h00, q);
  endtask

  task automatic ack(output logic [7:0] q);
    cycle(4'h9, 2'b00, 8'h00, q);
  endtask
endmodule // host_bus_model

`default_nettype wire

/* testbench/counter_timer_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module counter_timer_unit_bench;
  logic clk;
  logic srst = 1'b1;
  logic [3:0] trig = 4'hA;
  logic [7:0] bus;
  logic [7:0] host_d;
  logic [7:0] dout;
  logic dout_oe;
  logic cs_lo;
  logic cs_hi;
  logic ce_n;
  logic m1_n;
  logic iorq_n;
  logic rd_n;
  logic int_oe;
  logic int_n;
  logic iei = 1'b1;
  logic ieo;
  logic [2:0] zc;
  logic [7:0] q;
  logic [7:0] vec;
  logic [7:0] md[3] = '{8'h07, 8'h27, 8'h1F};
  int tcs[3] = '{3, 1, 1};
  int exp_per[$] = '{48, 256, 16};
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  int t_zc;
  int n_zc[3] = '{0, 0, 0};
  int tcv[4];
  int cnt[4];
  int exp_zc[4] = '{0, 0, 0, 0};
  bit run[4];

  assign bus = dout_oe ? dout : host_d;

  counter_timer_unit uut (
    .I_CLOCK(clk), .I_SRST(srst), .I_DATA(bus), .O_DATA(dout), .O_DATA_OE(dout_oe),
    .I_CHANNEL_SELECT_LOW(cs_lo), .I_CHANNEL_SELECT_HIGH(cs_hi), .I_CHIP_ENABLE_N(ce_n),
    .I_M1_N(m1_n), .I_IORQ_N(iorq_n), .I_RD_N(rd_n), .O_INT_N(int_n), .O_INT_N_OE(int_oe),
    .I_IEI(iei), .O_IEO(ieo), .I_EXT_COUNT_TRIGGER(trig), .O_ZERO_COUNT_PULSE_OUT(zc));

  host_bus_model host (
    .i_clock(clk), .i_data(bus), .o_data(host_d), .o_cs_low(cs_lo), .o_cs_high(cs_hi),
    .o_ce_n(ce_n), .o_m1_n(m1_n), .o_iorq_n(iorq_n), .o_rd_n(rd_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (zc[2] === 1'b1) t_zc <= cyc;
    for (int i = 0; i < 3; i++) n_zc[i] <= n_zc[i] + int'(zc[i] === 1'b1);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One active edge per pulse; the model tracks the count
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk);
      trig[ch] <= ~trig[ch];
      repeat (2) @(posedge clk);
      trig[ch] <= ~trig[ch];
      repeat (2) @(posedge clk);
      if (run[ch]) begin
        cnt[ch]--;
        if (cnt[ch] == 0) begin
          cnt[ch] = tcv[ch];
          exp_zc[ch]++;
        end
      end
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic rdchk(input int ch);
    host.rd(2'(ch), q);
    check(16'(q), 16'(cnt[ch] & 255));
    if (ch < 3) check(16'(n_zc[ch]), 16'(exp_zc[ch]));
  endtask

  task automatic wait_zc;
    int i;
    int n;
    n = n_zc[2];
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      #1;
      if (n_zc[2] != n) break;
    end
    if (i == 1000) n_errors++;
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(72364));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    pulse(0, 2);
    check(16'(n_zc[0]), 16'h0000);
    for (int ch = 0; ch < 4; ch++) begin
      tcv[ch] = $urandom_range(4, 1);
      host.wr(2'(ch), ch[0] ? 8'h45 : 8'h55);
      host.wr(2'(ch), 8'(tcv[ch]));
      cnt[ch] = tcv[ch];
      run[ch] = 1'b1;
      pulse(ch, 2 * tcv[ch] + 1);
      rdchk(ch);
    end
    check(16'(int_oe), 16'h0000);
    host.wr(2'd0, 8'h03);
    run[0] = 1'b0;
    pulse(0, 3);
    rdchk(0);
    host.wr(2'd1, 8'h47);
    host.wr(2'd1, 8'h00);
    tcv[1] = 256;
    cnt[1] = 256;
    pulse(1, 257);
    rdchk(1);
    run[2] = 1'b0;
    for (int k = 0; k < 3; k++) begin
      host.wr(2'd2, md[k]);
      host.wr(2'd2, 8'(tcs[k]));
      if (k == 2) begin
        t0 = n_zc[2];
        repeat (40) @(posedge clk);
        check(16'(n_zc[2] - t0), 16'h0000);
        pulse(2, 1);
      end
      wait_zc();
      t0 = t_zc;
      wait_zc();
      check(16'(t_zc - t0), 16'(exp_per[k]));
    end
    vec = 8'($urandom) & 8'hF8;
    host.wr(2'd0, vec);
    host.wr(2'd3, 8'hC1);
    check(16'(int_oe), 16'h0000);
    pulse(3, cnt[3]);
    check(16'(int_oe), 16'h0001);
    check(16'(int_n), 16'h0000);
    // Chain blocked: acknowledge must not be answered
    iei <= 1'b0;
    host.ack(q);
    check(16'(q), 16'h0000);
    check(16'(ieo), 16'h0000);
    check(16'(int_oe), 16'h0001);
    iei <= 1'b1;
    host.ack(q);
    check(16'(q), {8'h00, vec[7:3], 2'b11, 1'b0});
    check(16'(ieo), 16'h0000);
    check(16'(int_oe), 16'h0000);
    // Return-from-interrupt fetch pair frees the chain
    host.cycle(4'hA, 2'b00, 8'hED, q);
    host.cycle(4'hA, 2'b00, 8'h4D, q);
    check(16'(ieo), 16'h0001);
    report_and_stop();
  end
endmodule // counter_timer_unit_bench

`default_nettype wire
